// >>> scs_clock_control.sv
// system clock source select, hf oscillator trim, divide and suspend
// assumes oscillator outputs arrive as asynchronous levels oversampled
// by clk_sys, and wake sources are logic on clk_sys
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_control #(
   // factory trim for the 24.5 MHz point; per part, plain default here
   parameter logic [6:0] HF_TRIM_FACTORY = 7'h40
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register port
   input wire scs_pkg::scs_bus_req_t busReq,
   output logic [7:0] readData,
   // oscillator levels
   input wire logic hfOscLevel,
   input wire logic extOscLevel,
   input wire logic lfOscLevel,
   // lf scaling from the lf control register
   input wire logic [1:0] lfDivideSelect,
   // wake sources
   input wire scs_pkg::scs_wake_t wakeIn,
   // to the analog hf oscillator
   output logic hfOscEnable,
   output logic hfOscSuspend,
   output logic [6:0] hfPeriodTrim,
   // derived clock and status
   output logic coreClock,
   output logic coreClockStopped,
   output logic [1:0] activeSource
);

   // software-visible state
   logic [1:0] sourceField; // requested system clock source
   logic [6:0] trimField; // hf period trim
   logic enableBit; // hf oscillator enable
   logic suspendBit; // hf suspend request
   logic [1:0] hfDivide; // hf post-divide code
   scs_pkg::scs_susp_t suspState; // suspend sequence

   // synchronisers for the oscillator levels
   logic hfMeta;
   logic hfSync;
   logic extMeta;
   logic extSync;
   logic lfMeta;
   logic lfSync;

   // address decode
   logic hitSource;
   logic hitControl;
   logic hitTrim;
   logic wrSource;
   logic wrControl;
   logic wrTrim;

   // derived terms
   logic wakeEvent;
   logic readyFlag;
   logic syncFlag;
   logic hfGated;
   logic hfDivided;
   logic lfDivided;
   logic stopReq;
   logic muxStopped;
   logic [1:0] muxActive;
   logic legalSource;
   logic [7:0] sourceRead;
   logic [7:0] controlRead;
   logic [7:0] trimRead;

   // next values
   logic [1:0] next_sourceField;
   logic [6:0] next_trimField;
   logic next_enableBit;
   logic next_suspendBit;
   logic [1:0] next_hfDivide;
   logic [7:0] next_readData;
   scs_pkg::scs_susp_t next_suspState;

   // two-flop synchronisers; only the second stage is read
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         hfMeta <= 1'b0;
         hfSync <= 1'b0;
         extMeta <= 1'b0;
         extSync <= 1'b0;
         lfMeta <= 1'b0;
         lfSync <= 1'b0;
      end else begin
         hfMeta <= hfOscLevel;
         hfSync <= hfMeta;
         extMeta <= extOscLevel;
         extSync <= extMeta;
         lfMeta <= lfOscLevel;
         lfSync <= lfMeta;
      end
   end

   // register decode
   assign hitSource = (busReq.addr == scs_pkg::ADDR_SOURCE_SELECT);
   assign hitControl = (busReq.addr == scs_pkg::ADDR_HF_CONTROL);
   assign hitTrim = (busReq.addr == scs_pkg::ADDR_HF_TRIM);
   assign wrSource = busReq.wr && hitSource;
   assign wrControl = busReq.wr && hitControl;
   assign wrTrim = busReq.wr && hitTrim;

   // reserved code 11 is refused so the field always names a real source
   assign legalSource = (busReq.wdata[1:0] != scs_pkg::SRC_RESERVED);
   // only bits 1:0 are stored; the rest never reach a flop
   assign next_sourceField = (wrSource && legalSource) ?
      busReq.wdata[1:0] : sourceField;

   // trim keeps bits 6:0; bit 7 written is dropped
   assign next_trimField = wrTrim ? busReq.wdata[6:0] : trimField;

   // control register writable fields
   assign next_enableBit = wrControl ?
      busReq.wdata[scs_pkg::CTL_ENABLE_BIT] : enableBit;
   assign next_hfDivide = wrControl ?
      busReq.wdata[scs_pkg::CTL_DIV_LSB +: 2] : hfDivide;

   // any of four wake sources ends a suspend
   assign wakeEvent = wakeIn.port0Match | wakeIn.port1Match |
      (wakeIn.cmp0Enabled & ~wakeIn.cmp0Output) |
      wakeIn.timer3Overflow;

   // wake wins over a suspend write landing in the same cycle,
   // so the core can never sleep past an event it already raised
   assign next_suspendBit = wakeEvent ? 1'b0 :
      (wrControl ? busReq.wdata[scs_pkg::CTL_SUSPEND_BIT] :
       suspendBit);

   // status flags
   assign readyFlag = enableBit & ~suspendBit;
   assign syncFlag = (suspState == scs_pkg::SUSP_WAIT);

   // read images
   assign sourceRead = {6'h00, sourceField};
   assign trimRead = {1'b0, trimField};
   assign controlRead = {enableBit, readyFlag, suspendBit, syncFlag,
                         2'h0, hfDivide};

   // read mux; unmapped addresses answer zero
   assign next_readData = !busReq.rd ? scs_pkg::RST_READ_DATA :
      hitSource ? sourceRead :
      hitControl ? controlRead :
      hitTrim ? trimRead :
      scs_pkg::RST_READ_DATA;

   // register flops
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sourceField <= scs_pkg::RST_SOURCE;
         trimField <= HF_TRIM_FACTORY;
         enableBit <= scs_pkg::RST_ENABLE;
         suspendBit <= scs_pkg::RST_SUSPEND;
         hfDivide <= scs_pkg::RST_DIVIDE;
         readData <= scs_pkg::RST_READ_DATA;
      end else begin
         sourceField <= next_sourceField;
         trimField <= next_trimField;
         enableBit <= next_enableBit;
         suspendBit <= next_suspendBit;
         hfDivide <= next_divideOrKeep(next_hfDivide);
         readData <= next_readData;
      end
   end

   // identity pass kept as a hook for ratio qualification
   function automatic logic [1:0] next_divideOrKeep(input logic [1:0] d);
      next_divideOrKeep = d;
   endfunction

   // suspend sequence: wait for the gate to close, then halt
   always_comb begin
      next_suspState = suspState;
      case (suspState)
         scs_pkg::SUSP_RUN: begin
            if (stopReq) begin
               next_suspState = scs_pkg::SUSP_WAIT;
            end
         end
         scs_pkg::SUSP_WAIT: begin
            if (!suspendBit) begin
               next_suspState = scs_pkg::SUSP_RUN;
            end else if (muxStopped) begin
               next_suspState = scs_pkg::SUSP_HALT;
            end
         end
         scs_pkg::SUSP_HALT: begin
            // clock resumes where it stopped: the core simply
            // carries on past the suspend write
            if (!muxStopped) begin
               next_suspState = scs_pkg::SUSP_RUN;
            end
         end
         default: begin
            next_suspState = scs_pkg::SUSP_RUN;
         end
      endcase
   end

   // suspend state flop
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         suspState <= scs_pkg::SUSP_RUN;
      end else begin
         suspState <= next_suspState;
      end
   end

   // a disabled oscillator produces no edges; suspend is left to the
   // stop gate, as dropping the level here would cut a high phase short
   // and could freeze a divided level high so the gate never closes
   assign hfGated = hfSync & enableBit;
   // suspend stops the core only while hf is the live source
   assign stopReq = suspendBit && (muxActive == scs_pkg::SRC_HF);

   // hf post-divider
   scs_divider hfDiv (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .srcLevel(hfGated),
      .divSelect(hfDivide),
      .divClock(hfDivided)
   );

   // lf post-scaler, same ratio coding as the hf path
   scs_divider lfDiv (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .srcLevel(lfSync),
      .divSelect(lfDivideSelect),
      .divClock(lfDivided)
   );

   // source selector; software must pick a running source or the
   // switch waits forever for the new level to be seen falling
   scs_clock_mux srcMux (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .hfLevel(hfDivided),
      .extLevel(extSync),
      .lfLevel(lfDivided),
      .reqSel(sourceField),
      .stopReq(stopReq),
      .muxClock(coreClock),
      .activeSel(muxActive),
      .stopped(muxStopped)
   );

   // outputs to the analog oscillator and status
   assign hfOscEnable = enableBit;
   assign hfOscSuspend = suspendBit;
   // larger code lengthens the period, zero is fastest
   assign hfPeriodTrim = trimField;
   assign coreClockStopped = muxStopped;
   assign activeSource = muxActive;

endmodule
`default_nettype wire

// >>> scs_clock_control_properties.sv
// concurrent checks on the clock select block's ports
// assumes one clk_sys domain and the active-high async reset sys_rst
`timescale 1ns/1ps
`default_nettype none
module scs_clock_control_properties (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register port and wake sources
   input wire scs_pkg::scs_bus_req_t busReq,
   input wire logic [7:0] readData,
   input wire scs_pkg::scs_wake_t wakeIn,
   // block outputs
   input wire logic hfOscEnable,
   input wire logic hfOscSuspend,
   input wire logic [6:0] hfPeriodTrim,
   input wire logic coreClock,
   input wire logic coreClockStopped
);
   // any wake condition; a disabled comparator never counts
   wire logic wake = wakeIn.port0Match | wakeIn.port1Match |
      (wakeIn.cmp0Enabled & ~wakeIn.cmp0Output) | wakeIn.timer3Overflow;
   wire logic wrCtl = busReq.wr && busReq.addr == scs_pkg::ADDR_HF_CONTROL;
   wire logic wrTrim = busReq.wr && busReq.addr == scs_pkg::ADDR_HF_TRIM;
   wire logic rdSrc = busReq.rd && busReq.addr == scs_pkg::ADDR_SOURCE_SELECT;
   wire logic rdCtl = busReq.rd && busReq.addr == scs_pkg::ADDR_HF_CONTROL;
   wire logic rdTrim = busReq.rd && busReq.addr == scs_pkg::ADDR_HF_TRIM;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // wake seen while the oscillator is suspended
   sequence s_woken;
      wake && hfOscSuspend;
   endsequence
   // suspend bit drops, then the stop gate reopens in bounded time
   sequence s_resume;
      !hfOscSuspend ##[0:40] !coreClockStopped;
   endsequence
   // phases no shorter than the fastest source phase of three cycles
   property p_phase;
      ($rose(coreClock) |=> coreClock [*2]) and
      ($fell(coreClock) |=> !coreClock [*2]);
   endproperty

   a_src_upper: assert property (rdSrc |=> readData[7:2] == 6'h00)
      else $error("source select upper bits not zero");
   a_trim_upper: assert property (rdTrim |=> !readData[7])
      else $error("trim bit 7 not zero");
   a_ctl_layout: assert property (rdCtl |=>
      readData[7] == $past(hfOscEnable) && readData[5] == $past(hfOscSuspend))
      else $error("control readback disagrees with outputs");
   a_suspend_set: assert property (wrCtl && busReq.wdata[5] && !wake
      |=> hfOscSuspend)
      else $error("suspend write not taken");
   a_enable_write: assert property (wrCtl |=>
      hfOscEnable == $past(busReq.wdata[7]))
      else $error("enable bit not written");
   a_trim_write: assert property (wrTrim |=>
      hfPeriodTrim == $past(busReq.wdata[6:0]))
      else $error("trim not written");
   a_wake_resume: assert property (s_woken |=> s_resume)
      else $error("wake did not resume clocking");
   a_stop_low: assert property (coreClockStopped |-> !coreClock)
      else $error("stopped clock not held low");
   a_phase_min: assert property (p_phase)
      else $error("core clock phase too short");
endmodule
`default_nettype wire

// >>> scs_clock_mux.sv
// glitch-free three-way clock level selector with a stop gate
// assumes all levels are synchronised to clk_sys
`timescale 1ns/1ps
`default_nettype none
module scs_clock_mux (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // candidate levels indexed by source code
   input wire logic hfLevel,
   input wire logic extLevel,
   input wire logic lfLevel,
   // control
   input wire logic [1:0] reqSel,
   input wire logic stopReq,
   // result
   output logic muxClock,
   output logic [1:0] activeSel,
   output logic stopped
);

   logic curLevel;
   logic reqLevel;
   logic canSwitch;
   logic holdStop;
   logic prevHf; // source levels one cycle back
   logic prevExt;
   logic prevLf;
   logic reqFell; // requested source has just fallen
   logic [1:0] next_activeSel;
   logic next_stopped;
   logic next_muxClock;

   // level of a given source code
   function automatic logic levelOf(input logic [1:0] code,
                                    input logic hf,
                                    input logic ext,
                                    input logic lf);
      case (code)
         scs_pkg::SRC_HF: levelOf = hf;
         scs_pkg::SRC_EXT: levelOf = ext;
         scs_pkg::SRC_LF: levelOf = lf;
         default: levelOf = 1'b0;
      endcase
   endfunction

   assign curLevel = levelOf(activeSel, hfLevel, extLevel, lfLevel);
   assign reqLevel = levelOf(reqSel, hfLevel, extLevel, lfLevel);
   // a fresh fall of the new source means a whole low phase lies ahead;
   // switching on a bare low level could leave a runt low of one cycle
   assign reqFell = levelOf(reqSel, prevHf, prevExt, prevLf) && !reqLevel;
   // switch only at that fall, while the output already sits low
   assign canSwitch = (reqSel != activeSel) && !muxClock && reqFell;
   assign next_activeSel = canSwitch ? reqSel : activeSel;
   // stop engages in a low phase, releases only with the source low
   assign holdStop = muxClock || (stopped && curLevel);
   assign next_stopped = holdStop ? stopped : stopReq;
   assign next_muxClock = next_stopped ? 1'b0 :
      levelOf(next_activeSel, hfLevel, extLevel, lfLevel);

   // selection and output flops
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         activeSel <= scs_pkg::RST_SOURCE;
         stopped <= 1'b0;
         muxClock <= 1'b0;
         prevHf <= 1'b0;
         prevExt <= 1'b0;
         prevLf <= 1'b0;
      end else begin
         prevHf <= hfLevel;
         prevExt <= extLevel;
         prevLf <= lfLevel;
         activeSel <= next_activeSel;
         stopped <= next_stopped;
         muxClock <= next_muxClock;
      end
   end

endmodule
`default_nettype wire

// >>> scs_divider.sv
// post-divider for an oversampled oscillator level
// assumes srcLevel is already synchronised to clk_sys
`timescale 1ns/1ps
`default_nettype none
module scs_divider (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // source and ratio
   input wire logic srcLevel,
   input wire logic [1:0] divSelect,
   // divided level
   output logic divClock
);

   logic prevLevel; // last sampled source level
   logic [2:0] divCount; // rising edges seen
   logic [1:0] activeDiv; // ratio in force
   logic riseSeen;
   logic ratioSwap;
   logic [2:0] next_divCount;
   logic [1:0] next_activeDiv;
   logic next_divClock;

   // pick the tap for a ratio code
   function automatic logic pickTap(input logic [1:0] code,
                                    input logic lvl,
                                    input logic [2:0] cnt);
      case (code)
         scs_pkg::DIV_BY_1: pickTap = lvl;
         scs_pkg::DIV_BY_2: pickTap = cnt[0];
         scs_pkg::DIV_BY_4: pickTap = cnt[1];
         default: pickTap = cnt[2];
      endcase
   endfunction

   assign riseSeen = srcLevel & ~prevLevel;
   // at count zero with source low every tap is low, so no runt pulse
   assign ratioSwap = (divSelect != activeDiv) &&
                      (divCount == scs_pkg::RST_DIV_COUNT) && !srcLevel;
   assign next_divCount = riseSeen ? divCount + 3'h1 : divCount;
   assign next_activeDiv = ratioSwap ? divSelect : activeDiv;
   assign next_divClock = pickTap(activeDiv, srcLevel, divCount);

   // counter, ratio and output flops
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prevLevel <= 1'b0;
         divCount <= scs_pkg::RST_DIV_COUNT;
         activeDiv <= scs_pkg::RST_DIVIDE;
         divClock <= 1'b0;
      end else begin
         prevLevel <= srcLevel;
         divCount <= next_divCount;
         activeDiv <= next_activeDiv;
         divClock <= next_divClock;
      end
   end

endmodule
`default_nettype wire

// >>> scs_osc_model.sv
// oscillator sources and core-side clock period meter
// assumes levels are made from clk_sys counts, so phases are exact
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model #(
   parameter int HF_HALF = 3,
   parameter int EXT_HALF = 5,
   parameter int LF_HALF = 7
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // derived clock from the block
   input wire logic coreClock,
   // oscillator levels
   output logic hfLevel,
   output logic extLevel,
   output logic lfLevel,
   // cycles between the last two rising core clock edges
   output int period
);
   int hfCnt, extCnt, lfCnt, runCnt; // phase and period counters
   logic lastCore; // core clock one cycle back

   // every source enabled and running, so any switch may complete
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         {hfCnt, extCnt, lfCnt} <= '0;
         {hfLevel, extLevel, lfLevel} <= 3'h0;
      end else begin
         hfCnt <= (hfCnt == HF_HALF - 1) ? 0 : hfCnt + 1;
         extCnt <= (extCnt == EXT_HALF - 1) ? 0 : extCnt + 1;
         lfCnt <= (lfCnt == LF_HALF - 1) ? 0 : lfCnt + 1;
         hfLevel <= hfLevel ^ (hfCnt == HF_HALF - 1);
         extLevel <= extLevel ^ (extCnt == EXT_HALF - 1);
         lfLevel <= lfLevel ^ (lfCnt == LF_HALF - 1);
      end
   end

   // period meter; stale while the clock is held stopped
   always @(posedge clk_sys) begin
      lastCore <= coreClock;
      runCnt <= (coreClock && !lastCore) ? 1 : runCnt + 1;
      if (coreClock && !lastCore) begin
         period <= runCnt;
      end
   end
endmodule
`default_nettype wire

// >>> scs_pkg.sv
// package for the system clock select and hf oscillator control block
// assumes byte-wide special registers on a plain strobe port, one clock
// Behaviour
// - source 00 selects divided hf oscillator
// - source 01 selects external oscillator input
// - source 10 selects scaled lf; 11 reserved
// - source register bits 7:2 read zero
// - reset selects the hf oscillator
// - hf path divides by 1, 2, 4, 8
// - hf divide resets to divide-by-8
// - writing suspend bit 5 suspends hf oscillator
// - suspended hf source holds core clock stopped
// - four wake events: two matches, comparator, timer
// - any wake event resumes normal clocking
// - core continues after the suspend write
// - seven-bit trim: zero fastest, ones slowest
// - trim resets to factory 24.5 MHz value
// - trim register bit 7 reads zero
// - control register field layout and resets
// - control bit 7 enables hf oscillator
// - on-the-fly switching, only to running source
package scs_pkg;

   // register addresses
   localparam logic [7:0] ADDR_SOURCE_SELECT = 8'ha9;
   localparam logic [7:0] ADDR_HF_CONTROL = 8'hb2;
   localparam logic [7:0] ADDR_HF_TRIM = 8'hb3;

   // source select field codes
   localparam logic [1:0] SRC_HF = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;
   localparam logic [1:0] SRC_LF = 2'h2;
   localparam logic [1:0] SRC_RESERVED = 2'h3;

   // divide select codes
   localparam logic [1:0] DIV_BY_8 = 2'h0;
   localparam logic [1:0] DIV_BY_4 = 2'h1;
   localparam logic [1:0] DIV_BY_2 = 2'h2;
   localparam logic [1:0] DIV_BY_1 = 2'h3;

   // control register bit positions
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_READY_BIT = 6;
   localparam int CTL_SUSPEND_BIT = 5;
   localparam int CTL_SYNC_BIT = 4;
   localparam int CTL_DIV_LSB = 0;

   // values after reset
   localparam logic [1:0] RST_SOURCE = SRC_HF;
   localparam logic [1:0] RST_DIVIDE = DIV_BY_8;
   localparam logic RST_ENABLE = 1'b1;
   localparam logic RST_SUSPEND = 1'b0;
   localparam logic [7:0] RST_READ_DATA = 8'h00;
   localparam logic [2:0] RST_DIV_COUNT = 3'h0;

   // register bus request from the core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } scs_bus_req_t;

   // wake sources from the peripherals
   typedef struct packed {
      logic port0Match;
      logic port1Match;
      logic cmp0Enabled;
      logic cmp0Output;
      logic timer3Overflow;
   } scs_wake_t;

   // suspend sequencing
   typedef enum logic [2:0] {
      SUSP_RUN = 3'h1,
      SUSP_WAIT = 3'h2,
      SUSP_HALT = 3'h4
   } scs_susp_t;

endpackage

// >>> tb_top.sv
// self-checking bench for the clock select block
// assumes free-running model oscillators and a plain strobe register port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int HF_H = 3; // half periods in clk_sys cycles
   localparam int EXT_H = 5;
   localparam int LF_H = 7;
   localparam logic [6:0] TRIM0 = 7'h40; // arbitrary factory stand-in
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   scs_pkg::scs_bus_req_t busReq = '0;
   scs_pkg::scs_wake_t wakeIn = '0;
   logic [1:0] lfDivideSelect = 2'h3;
   logic [7:0] readData, d;
   logic hfLevel, extLevel, lfLevel, hfOscEnable, hfOscSuspend;
   logic [6:0] hfPeriodTrim;
   logic coreClock, coreClockStopped;
   logic [1:0] activeSource;
   logic [4:0] wkTab [4] = '{5'h10, 5'h08, 5'h04, 5'h01}; // one per kind
   int period, i, k;
   int miscompares = 0;
   int n_checks = 0;

   always #4 clk_sys = ~clk_sys;

   scs_clock_control #(.HF_TRIM_FACTORY(TRIM0)) i_scs_clock_control (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .busReq(busReq),
      .readData(readData), .hfOscLevel(hfLevel), .extOscLevel(extLevel),
      .lfOscLevel(lfLevel), .lfDivideSelect(lfDivideSelect),
      .wakeIn(wakeIn), .hfOscEnable(hfOscEnable),
      .hfOscSuspend(hfOscSuspend), .hfPeriodTrim(hfPeriodTrim),
      .coreClock(coreClock), .coreClockStopped(coreClockStopped),
      .activeSource(activeSource));
   scs_osc_model #(.HF_HALF(HF_H), .EXT_HALF(EXT_H), .LF_HALF(LF_H))
      i_scs_osc_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .coreClock(coreClock), .hfLevel(hfLevel), .extLevel(extLevel),
      .lfLevel(lfLevel), .period(period));

   // expected period for a half period and a divide code
   function automatic int per(input int half, input logic [1:0] c);
      return 2 * half * (8 >> c);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      busReq.addr <= a;
      busReq.wdata <= v;
      busReq.wr <= 1'b1;
      @(posedge clk_sys);
      busReq.wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge clk_sys);
      busReq.rd <= 1'b0;
      #1 check(readData, e);
   endtask

   // three full periods of the new setting, plus the wait of a ratio swap
   // for the eight-edge count to wrap, which can take 112 cycles on lf
   task automatic per_chk(input int exp);
      repeat (3 * exp + 200) @(posedge clk_sys);
      check(period, exp);
   endtask

   task automatic wait_src(input logic [1:0] c);
      for (i = 0; i < 400 && activeSource !== c; i++) @(posedge clk_sys);
      check(activeSource, c);
   endtask

   task automatic finish_test;
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // watchdog well beyond the expected run
   initial begin
      repeat (30000) @(posedge clk_sys);
      miscompares++;
      finish_test;
   end

   initial begin
      void'($urandom(32'h7191));
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd_chk(8'ha9, 8'h00);
      rd_chk(8'hb2, 8'hc0);
      rd_chk(8'hb3, {1'b0, TRIM0});
      rd_chk(8'h5e, 8'h00);
      per_chk(per(HF_H, 2'h0));
      for (k = 0; k < 4; k++) begin
         wr(8'hb2, 8'h80 | k[7:0]);
         rd_chk(8'hb2, 8'hc0 | k[7:0]);
         per_chk(per(HF_H, k[1:0]));
      end
      // suspend, then wake by each kind; comparator high is no wake
      for (k = 0; k < 4; k++) begin
         wr(8'hb2, 8'ha3);
         wakeIn <= 5'h06;
         repeat (20) @(posedge clk_sys);
         check(coreClockStopped, 1'b1);
         rd_chk(8'hb2, 8'ha3);
         wakeIn <= wkTab[k];
         @(posedge clk_sys);
         wakeIn <= '0;
         for (i = 0; i < 40 && coreClockStopped; i++) @(posedge clk_sys);
         check(coreClockStopped, 1'b0);
         rd_chk(8'hb2, 8'hc3);
      end
      for (k = 0; k < 4; k++) begin
         d = (k == 0) ? 8'hff : (k == 1) ? 8'h80 : 8'($urandom);
         wr(8'hb3, d);
         rd_chk(8'hb3, {1'b0, d[6:0]});
         check(hfPeriodTrim, d[6:0]);
      end
      d = 8'($urandom);
      wr(8'ha9, {d[7:2], 2'h1});
      rd_chk(8'ha9, 8'h01);
      wait_src(2'h1);
      per_chk(2 * EXT_H);
      wr(8'ha9, 8'hff);
      rd_chk(8'ha9, 8'h01);
      wr(8'hb2, 8'h03);
      rd_chk(8'hb2, 8'h03);
      check(hfOscEnable, 1'b0);
      wr(8'hb2, 8'h83);
      lfDivideSelect <= 2'($urandom);
      wr(8'ha9, 8'h02);
      wait_src(2'h2);
      per_chk(per(LF_H, lfDivideSelect));
      wr(8'ha9, 8'h00);
      wait_src(2'h0);
      per_chk(per(HF_H, 2'h3));
      finish_test;
   end
endmodule

bind scs_clock_control scs_clock_control_properties
   i_scs_clock_control_properties (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .busReq(busReq), .readData(readData), .wakeIn(wakeIn),
   .hfOscEnable(hfOscEnable), .hfOscSuspend(hfOscSuspend),
   .hfPeriodTrim(hfPeriodTrim), .coreClock(coreClock),
   .coreClockStopped(coreClockStopped));
`default_nettype wire
